// file: clkbuf_pkg.sv
// shared constants and strap decode tables for the clock buffer control pins
package clkbuf_pkg;
  localparam int NUM_OUT    = 4;
  localparam int DIV_W      = 10;
  localparam int LVL_W      = 3;
  localparam int STD_W      = 2;
  localparam int ADDR_W     = 7;
  localparam int DATA_W     = 16;
  localparam int CMD_BITS   = 8;
  localparam int FRAME_BITS = 24;
  localparam int BYTE_BITS  = 8;
  localparam int NUM_STRAP  = 6;
  localparam logic [1:0] SEL_SPI = 2'h0;
  localparam logic [1:0] SEL_I2C = 2'h1;
  typedef enum logic [1:0] {SRC_SPI, SRC_I2C, SRC_STRAP} src_t;
  localparam logic [STD_W-1:0] STD_LVDS = 2'h0;
  localparam logic [STD_W-1:0] STD_HSTL = 2'h1;
  localparam logic [STD_W-1:0] STD_CMOS = 2'h2;
  localparam logic [DIV_W-1:0] DIV_DEFAULT   = 10'h000;
  localparam logic [DIV_W-1:0] DIV_STRAP_MAX = 10'h00f;
  localparam logic [STD_W-1:0] STD_DEFAULT   = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_STD_A = 7'h04;
  localparam logic [ADDR_W-1:0] ADDR_STD_B = 7'h05;
  localparam logic [6:0] I2C_DEV_ADDR = 7'h30;
  // positions inside the synchronised pin vector
  localparam int P_RESET = 0;
  localparam int P_SYNC  = 1;
  localparam int P_INSEL = 2;
  localparam int P_SEL   = 3;
  localparam int P_CS    = 5;
  localparam int P_SCLK  = 6;
  localparam int P_SDIO  = 7;
  localparam int P_REFP  = 8;
  localparam int P_REFN  = 9;
  localparam int P_STRAP = 10;
  localparam int PIN_W   = 28;
  // reset, sync and chip select idle high
  localparam logic [PIN_W-1:0] PIN_IDLE = 28'h0000023;

  function automatic logic [DIV_W-1:0] strap_div(input logic [LVL_W-1:0] l);
    unique case (l)
      3'h0: strap_div = 10'h000;
      3'h1: strap_div = 10'h001;
      3'h2: strap_div = 10'h002;
      3'h3: strap_div = 10'h003;
      3'h4: strap_div = 10'h004;
      3'h5: strap_div = 10'h005;
      3'h6: strap_div = 10'h007;
      3'h7: strap_div = 10'h00f;
    endcase
  endfunction

  function automatic logic [STD_W-1:0] strap_std(input logic [LVL_W-1:0] l);
    if (l < 3'h3) strap_std = STD_LVDS;
    else if (l < 3'h6) strap_std = STD_HSTL;
    else strap_std = STD_CMOS;
  endfunction
endpackage

// file: clock_buffer_control_pins.sv
// control pins of a four-output clock buffer: source select, serial ports, straps
`timescale 1ns/100ps
module clock_buffer_control_pins (
  input  wire logic                        CLK,
  input  wire logic                        RST_N,
  input  wire logic                        CE,
  input  wire logic                        RESET_PIN_N,
  input  wire logic                        SYNC_PIN_N,
  input  wire logic                        IN_SEL,
  input  wire logic [1:0]                  PROGRAM_SOURCE_SELECT_CODE,
  input  wire logic                        THREE_WIRE,
  input  wire logic                        CS_N,
  input  wire logic                        SCLK,
  input  wire logic                        SDIO_IN,
  output logic                             SDIO_OUT,
  output logic                             SDIO_OE_N,
  output logic                             SDO_OUT,
  output logic                             SDO_OE_N,
  input  wire logic                        REF_P,
  input  wire logic                        REF_N,
  input  wire logic [2:0]                  STRAP_DIVIDER_OUT_0,
  input  wire logic [2:0]                  STRAP_DIVIDER_OUT_1,
  input  wire logic [2:0]                  STRAP_DIVIDER_OUT_2,
  input  wire logic [2:0]                  STRAP_DIVIDER_OUT_3,
  input  wire logic [2:0]                  STRAP_LEVEL_GROUP_A,
  input  wire logic [2:0]                  STRAP_LEVEL_GROUP_B,
  output logic                             CLOCK_OUTPUT_0,
  output logic                             CLOCK_OUTPUT_1,
  output logic                             CLOCK_OUTPUT_2,
  output logic                             CLOCK_OUTPUT_3,
  output logic [1:0]                       OUT_STD_0,
  output logic [1:0]                       OUT_STD_1,
  output logic [1:0]                       OUT_STD_2,
  output logic [1:0]                       OUT_STD_3,
  output clkbuf_pkg::src_t                 PROG_SOURCE,
  output logic                             POWER_DOWN,
  output logic                             REF_DIFF_MODE
);
  localparam int DW = clkbuf_pkg::DIV_W;
  localparam int SW = clkbuf_pkg::STD_W;
  localparam int N  = clkbuf_pkg::NUM_OUT;

  logic [clkbuf_pkg::PIN_W-1:0] meta_reg, meta_next, pin_reg, pin_next;
  logic rst_pin, sync_pin, in_sel, cs_n, sclk, sdio, refp, refn;
  logic [clkbuf_pkg::LVL_W-1:0] lvl [clkbuf_pkg::NUM_STRAP];
  logic [1:0] sel;

  // every pin except THREE_WIRE passes two flops; idle values keep reset and sync deasserted
  always_comb begin
    meta_next = meta_reg;
    pin_next  = pin_reg;
    if (!RST_N) begin
      meta_next = clkbuf_pkg::PIN_IDLE;
      pin_next  = clkbuf_pkg::PIN_IDLE;
    end else if (CE) begin
      meta_next = {STRAP_LEVEL_GROUP_B, STRAP_LEVEL_GROUP_A,
                   STRAP_DIVIDER_OUT_3, STRAP_DIVIDER_OUT_2,
                   STRAP_DIVIDER_OUT_1, STRAP_DIVIDER_OUT_0, REF_N, REF_P,
                   SDIO_IN, SCLK, CS_N, PROGRAM_SOURCE_SELECT_CODE, IN_SEL, SYNC_PIN_N,
                   RESET_PIN_N};
      pin_next  = meta_reg;
    end
  end

  always_ff @(posedge CLK) begin
    meta_reg <= meta_next;
    pin_reg  <= pin_next;
  end

  assign rst_pin  = pin_reg[clkbuf_pkg::P_RESET];
  assign sync_pin = pin_reg[clkbuf_pkg::P_SYNC];
  assign in_sel   = pin_reg[clkbuf_pkg::P_INSEL];
  assign sel      = pin_reg[clkbuf_pkg::P_SEL +: 2];
  assign cs_n     = pin_reg[clkbuf_pkg::P_CS];
  assign sclk     = pin_reg[clkbuf_pkg::P_SCLK];
  assign sdio     = pin_reg[clkbuf_pkg::P_SDIO];
  assign refp     = pin_reg[clkbuf_pkg::P_REFP];
  assign refn     = pin_reg[clkbuf_pkg::P_REFN];
  for (genvar k = 0; k < clkbuf_pkg::NUM_STRAP; k++) begin : g_lvl
    assign lvl[k] = pin_reg[clkbuf_pkg::P_STRAP + k*clkbuf_pkg::LVL_W +:
                            clkbuf_pkg::LVL_W];
  end

  clkbuf_pkg::src_t src_reg, src_next;
  logic pd_reg, pd_next, rdiff_reg, rdiff_next, pend_reg, pend_next;
  logic ref_reg, ref_next, refl_reg, refl_next, sync_l_reg, sync_l_next;
  logic sclk_l_reg, sclk_l_next, sdio_l_reg, sdio_l_next;
  logic [DW-1:0] div_reg [N];
  logic [DW-1:0] div_next [N];
  logic [DW-1:0] sdiv_reg [N];
  logic [DW-1:0] sdiv_next [N];
  logic [DW-1:0] eff_div [N];
  logic [SW-1:0] std_a_reg, std_a_next, std_b_reg, std_b_next;
  logic [SW-1:0] sstd_a_reg, sstd_a_next, sstd_b_reg, sstd_b_next;
  logic [SW-1:0] ostd_reg [N];
  logic [SW-1:0] ostd_next [N];
  logic [clkbuf_pkg::FRAME_BITS-2:0] sin_reg, sin_next;
  logic [clkbuf_pkg::DATA_W-1:0] sout_reg, sout_next;
  logic [4:0] scnt_reg, scnt_next;
  logic srd_reg, srd_next, bit_reg, bit_next, spi_go;
  logic i_act_reg, i_act_next, ack_reg, ack_next;
  logic [3:0] ibit_reg, ibit_next;
  logic [1:0] ibyte_reg, ibyte_next;
  logic [7:0] ish_reg, ish_next, ihi_reg, ihi_next;
  logic [clkbuf_pkg::ADDR_W-1:0] iadr_reg, iadr_next;
  logic sdo_oe_reg, sdo_oe_next, sdio_oe_reg, sdio_oe_next, sdio_o_reg;
  logic sdio_o_next;
  logic wr_en;
  logic [clkbuf_pkg::ADDR_W-1:0] wr_addr;
  logic [clkbuf_pkg::DATA_W-1:0] wr_data;
  logic strap_mode, ref_rise;
  logic run_reg, run_next;
  logic [1:0] primed_reg, primed_next;

  function automatic logic [clkbuf_pkg::DATA_W-1:0] rd_word(
    input logic [clkbuf_pkg::ADDR_W-1:0] a);
    rd_word = '0;
    if (a < clkbuf_pkg::ADDR_W'(N)) rd_word[DW-1:0] = div_reg[a[1:0]];
    else if (a == clkbuf_pkg::ADDR_STD_A) rd_word[SW-1:0] = std_a_reg;
    else if (a == clkbuf_pkg::ADDR_STD_B) rd_word[SW-1:0] = std_b_reg;
  endfunction

  assign strap_mode = (src_reg == clkbuf_pkg::SRC_STRAP);
  assign ref_rise   = ref_reg & ~refl_reg;
  assign spi_go     = (src_reg == clkbuf_pkg::SRC_SPI) && !cs_n;

  always_comb begin
    src_next = src_reg; pd_next = pd_reg; rdiff_next = rdiff_reg;
    pend_next = pend_reg; ref_next = ref_reg; refl_next = refl_reg;
    sync_l_next = sync_l_reg; sclk_l_next = sclk_l_reg;
    sdio_l_next = sdio_l_reg; div_next = div_reg; sdiv_next = sdiv_reg;
    std_a_next = std_a_reg; std_b_next = std_b_reg; ostd_next = ostd_reg;
    sstd_a_next = sstd_a_reg; sstd_b_next = sstd_b_reg;
    sin_next = sin_reg; sout_next = sout_reg; scnt_next = scnt_reg;
    srd_next = srd_reg; bit_next = bit_reg; i_act_next = i_act_reg;
    ack_next = ack_reg; ibit_next = ibit_reg; ibyte_next = ibyte_reg;
    ish_next = ish_reg; ihi_next = ihi_reg; iadr_next = iadr_reg;
    sdo_oe_next = sdo_oe_reg; sdio_oe_next = sdio_oe_reg;
    sdio_o_next = sdio_o_reg;
    run_next = run_reg; primed_next = primed_reg;
    wr_en = 1'b0; wr_addr = '0; wr_data = '0;
    if (!RST_N) begin
      src_next = clkbuf_pkg::SRC_SPI; pd_next = 1'b0; rdiff_next = 1'b0;
      pend_next = 1'b1; ref_next = 1'b0; refl_next = 1'b0;
      sync_l_next = 1'b1; sclk_l_next = 1'b0; sdio_l_next = 1'b0;
      for (int i = 0; i < N; i++) begin
        div_next[i] = clkbuf_pkg::DIV_DEFAULT;
        sdiv_next[i] = clkbuf_pkg::DIV_DEFAULT;
        ostd_next[i] = clkbuf_pkg::STD_DEFAULT;
      end
      std_a_next = clkbuf_pkg::STD_DEFAULT; std_b_next = std_a_next;
      sstd_a_next = std_a_next; sstd_b_next = std_a_next;
      sin_next = '0; sout_next = '0; scnt_next = '0; srd_next = 1'b0;
      bit_next = 1'b0; i_act_next = 1'b0; ack_next = 1'b0; ibit_next = '0;
      ibyte_next = '0; ish_next = '0; ihi_next = '0; iadr_next = '0;
      sdo_oe_next = 1'b1; sdio_oe_next = 1'b1; sdio_o_next = 1'b0;
      run_next = 1'b0; primed_next = '0;
    end else if (CE) begin
      if (sel == clkbuf_pkg::SEL_SPI) src_next = clkbuf_pkg::SRC_SPI;
      else if (sel == clkbuf_pkg::SEL_I2C) src_next = clkbuf_pkg::SRC_I2C;
      else src_next = clkbuf_pkg::SRC_STRAP;
      pd_next = !rst_pin;
      primed_next = {primed_reg[0], 1'b1};
      run_next = !pd_reg && sync_pin && (run_reg || ref_rise);
      rdiff_next = in_sel;
      // differential: follow the true pin only while the pair disagrees
      ref_next = (in_sel && refp == refn) ? ref_reg : refp;
      refl_next = ref_reg; sync_l_next = sync_pin;
      sclk_l_next = sclk; sdio_l_next = sdio;
      // SPI slave, frame: read flag, address, 16 data bits, msb first
      if (!spi_go) begin
        scnt_next = '0;
        srd_next = 1'b0;
      end else begin
        if (sclk && !sclk_l_reg && scnt_reg != 5'(clkbuf_pkg::FRAME_BITS))
        begin
          sin_next = {sin_reg[clkbuf_pkg::FRAME_BITS-3:0], sdio};
          scnt_next = scnt_reg + 5'h1;
          if (scnt_reg == 5'(clkbuf_pkg::CMD_BITS - 1)) begin
            srd_next = sin_reg[clkbuf_pkg::CMD_BITS-2];
            sout_next = rd_word({sin_reg[clkbuf_pkg::ADDR_W-2:0], sdio});
          end
          if (scnt_reg == 5'(clkbuf_pkg::FRAME_BITS - 1) && !srd_reg) begin
            wr_en = 1'b1;
            wr_addr = sin_reg[clkbuf_pkg::FRAME_BITS-3 -: clkbuf_pkg::ADDR_W];
            wr_data = {sin_reg[clkbuf_pkg::DATA_W-2:0], sdio};
          end
        end
        if (!sclk && sclk_l_reg && srd_reg) begin
          bit_next = sout_reg[clkbuf_pkg::DATA_W-1];
          sout_next = {sout_reg[clkbuf_pkg::DATA_W-2:0], 1'b0};
        end
      end
      // I2C slave on the same two pins, write only
      if (src_reg != clkbuf_pkg::SRC_I2C ||
          (sclk && sclk_l_reg && !sdio_l_reg && sdio)) begin
        i_act_next = 1'b0;
        ack_next = 1'b0;
      end else if (sclk && sclk_l_reg && sdio_l_reg && !sdio) begin
        i_act_next = 1'b1; ack_next = 1'b0; ibit_next = '0; ibyte_next = '0;
      end else if (i_act_reg) begin
        // bits count on scl rises; the fall after the eighth raises ack,
        // the next fall drops it; a fifth byte is not acknowledged
        if (sclk && !sclk_l_reg && ibit_reg < 4'(clkbuf_pkg::BYTE_BITS)) begin
          ish_next = {ish_reg[6:0], sdio};
          ibit_next = ibit_reg + 4'h1;
        end
        if (!sclk && sclk_l_reg && ack_reg) begin
          ibit_next = '0; ack_next = 1'b0;
          i_act_next = (ibyte_reg != 2'h3);
          ibyte_next = ibyte_reg + 2'h1;
        end else if (!sclk && sclk_l_reg &&
                     ibit_reg == 4'(clkbuf_pkg::BYTE_BITS)) begin
          ack_next = 1'b1;
          unique case (ibyte_reg)
            2'h0: ack_next = ish_reg[7:1] == clkbuf_pkg::I2C_DEV_ADDR &&
                             !ish_reg[0];
            2'h1: iadr_next = ish_reg[6:0];
            2'h2: ihi_next = ish_reg;
            2'h3: begin
              wr_en = 1'b1; wr_addr = iadr_reg; wr_data = {ihi_reg, ish_reg};
            end
          endcase
          i_act_next = ack_next;
        end
      end
      sdo_oe_next = !(spi_go && srd_reg && !THREE_WIRE);
      sdio_oe_next = !((spi_go && srd_reg && THREE_WIRE) || ack_reg);
      sdio_o_next = (src_reg == clkbuf_pkg::SRC_I2C) ? 1'b0 : bit_reg;
      if (wr_en && !strap_mode) begin
        if (wr_addr < clkbuf_pkg::ADDR_W'(N))
          div_next[wr_addr[1:0]] = wr_data[DW-1:0];
        else if (wr_addr == clkbuf_pkg::ADDR_STD_A) std_a_next = wr_data[SW-1:0];
        else if (wr_addr == clkbuf_pkg::ADDR_STD_B) std_b_next = wr_data[SW-1:0];
      end
      if (!rst_pin) begin
        pend_next = 1'b1; std_a_next = clkbuf_pkg::STD_DEFAULT;
        std_b_next = clkbuf_pkg::STD_DEFAULT;
        for (int i = 0; i < N; i++) div_next[i] = clkbuf_pkg::DIV_DEFAULT;
      end else if (pend_reg && primed_reg[1]) begin
        // wait until both sampler stages hold real strap levels
        pend_next = 1'b0;
        for (int i = 0; i < N; i++)
          sdiv_next[i] = clkbuf_pkg::strap_div(lvl[i]);
        sstd_a_next = clkbuf_pkg::strap_std(lvl[N]);
        sstd_b_next = clkbuf_pkg::strap_std(lvl[N+1]);
      end
      for (int i = 0; i < N; i++)
        ostd_next[i] = strap_mode ? ((i < N/2) ? sstd_a_reg : sstd_b_reg)
                                  : ((i < N/2) ? std_a_reg : std_b_reg);
    end
  end

  always_ff @(posedge CLK) begin
    src_reg <= src_next; pd_reg <= pd_next; rdiff_reg <= rdiff_next;
    pend_reg <= pend_next; ref_reg <= ref_next; refl_reg <= refl_next;
    sync_l_reg <= sync_l_next; sclk_l_reg <= sclk_l_next;
    sdio_l_reg <= sdio_l_next; div_reg <= div_next; sdiv_reg <= sdiv_next;
    std_a_reg <= std_a_next; std_b_reg <= std_b_next; ostd_reg <= ostd_next;
    sstd_a_reg <= sstd_a_next; sstd_b_reg <= sstd_b_next;
    sin_reg <= sin_next; sout_reg <= sout_next; scnt_reg <= scnt_next;
    srd_reg <= srd_next; bit_reg <= bit_next; i_act_reg <= i_act_next;
    ack_reg <= ack_next; ibit_reg <= ibit_next; ibyte_reg <= ibyte_next;
    ish_reg <= ish_next; ihi_reg <= ihi_next; iadr_reg <= iadr_next;
    sdo_oe_reg <= sdo_oe_next; sdio_oe_reg <= sdio_oe_next;
    sdio_o_reg <= sdio_o_next;
    run_reg <= run_next; primed_reg <= primed_next;
  end

  logic [N-1:0] out_v;
  logic [DW-1:0] cnt_v [N];
  for (genvar i = 0; i < N; i++) begin : g_out
    logic [DW-1:0] cnt_reg, cnt_next;
    logic out_reg, out_next;
    logic [DW:0] half;
    assign eff_div[i] = strap_mode ? sdiv_reg[i] : div_reg[i];
    assign half = ({1'b0, eff_div[i]} + (DW+1)'(2)) >> 1;
    always_comb begin
      cnt_next = cnt_reg;
      out_next = out_reg;
      if (!RST_N || pd_reg || !sync_pin) begin
        cnt_next = '0;
        out_next = 1'b0;
      end else if (CE) begin
        // stopped dividers restart together on the next reference rise,
        // and every output edge lands in the cycle the ratio-1 path moves
        if (ref_rise) cnt_next = (!run_reg || cnt_reg == eff_div[i]) ? '0
                                 : cnt_reg + DW'(1);
        if (!run_reg && !ref_rise)
          out_next = 1'b0;
        else
          out_next = (eff_div[i] == '0) ? ref_reg
                                        : ({1'b0, cnt_next} < half);
      end
    end
    always_ff @(posedge CLK) begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
    assign out_v[i] = out_reg;
    assign cnt_v[i] = cnt_reg;
  end

  assign CLOCK_OUTPUT_0 = out_v[0];
  assign CLOCK_OUTPUT_1 = out_v[1];
  assign CLOCK_OUTPUT_2 = out_v[2];
  assign CLOCK_OUTPUT_3 = out_v[3];
  assign OUT_STD_0 = ostd_reg[0];
  assign OUT_STD_1 = ostd_reg[1];
  assign OUT_STD_2 = ostd_reg[2];
  assign OUT_STD_3 = ostd_reg[3];
  assign PROG_SOURCE = src_reg;
  assign POWER_DOWN = pd_reg;
  assign REF_DIFF_MODE = rdiff_reg;
  assign SDO_OUT = bit_reg;
  assign SDO_OE_N = sdo_oe_reg;
  assign SDIO_OUT = sdio_o_reg;
  assign SDIO_OE_N = sdio_oe_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence sync_low_s; !sync_pin [*2]; endsequence
  logic [DW-1:0] div0;
  assign div0 = div_reg[0];

  pd_outputs_a: assert property (pd_reg |=> out_v == '0)
    else $error("outputs toggle while powered down");
  sync_hold_a: assert property (sync_low_s |-> out_v == '0)
    else $error("outputs not static while sync low");
  sync_align_a: assert property ($rose(sync_pin) |-> cnt_v[0] == '0 &&
    cnt_v[1] == '0 && cnt_v[2] == '0 && cnt_v[3] == '0)
    else $error("dividers not aligned at sync release");
  spi_idle_a: assert property (CE && !spi_go |=> scnt_reg == '0)
    else $error("spi frame kept while deselected");
  sdo_drive_a: assert property (CE && spi_go && srd_reg && !THREE_WIRE
    |=> !SDO_OE_N)
    else $error("read data not driven on serial output");
  three_wire_a: assert property (CE && THREE_WIRE |=> SDO_OE_N)
    else $error("serial output driven in 3-wire mode");
  std_serial_a: assert property (CE && !strap_mode |=>
    OUT_STD_0 == $past(std_a_reg) && OUT_STD_3 == $past(std_b_reg))
    else $error("strap standard used in serial mode");
  reset_dflt_a: assert property (CE && !rst_pin |=>
    div0 == clkbuf_pkg::DIV_DEFAULT)
    else $error("divider not default under reset");
  ref_single_a: assert property (CE && !in_sel |=> ref_reg == $past(refp))
    else $error("single-ended reference not followed");
  strap_max_a: assert property (strap_mode |->
    eff_div[2] <= clkbuf_pkg::DIV_STRAP_MAX)
    else $error("strap divider above 16");
endmodule

// file: serial_host.sv
// host serial controller model driving the spi and i2c pins of the device
`timescale 1ns/100ps
module serial_host (
  input  wire logic clk,
  input  wire logic i2c_mode,
  input  wire logic three_wire,
  input  wire logic sdio_out,
  input  wire logic sdio_oe_n,
  input  wire logic sdo_out,
  output logic      cs_n,
  output logic      sclk,
  output logic      sdio_line
);
  logic bit_q = 1'b1;
  logic drv   = 1'b0;
  logic last  = 1'b0;
  initial {cs_n, sclk} = 2'b10;
  // sda has a pull-up; a released spi line shows the inverse of its last level
  always_comb begin
    if (i2c_mode)
      sdio_line = (bit_q | !drv) & (sdio_oe_n | sdio_out);
    else if (!sdio_oe_n)
      sdio_line = sdio_out;
    else
      sdio_line = drv ? bit_q : ~last;
  end
  always @(posedge clk) if (drv || !sdio_oe_n) last <= sdio_line;
  // sel low models a frame meant for another device on the shared bus
  task automatic spi_frame(input logic [23:0] f, input logic sel,
                           output logic [15:0] q);
    q = 16'h0000;
    cs_n = !sel;
    for (int i = 23; i >= 0; i--) begin
      drv = (i > 15) || !f[23];
      bit_q = f[i];
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      if (i < 16)
        q[i] = three_wire ? sdio_line : sdo_out;
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    drv = 1'b0;
    cs_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task automatic i2c_write(input logic [31:0] b, output int acks);
    acks = 0;
    drv = 1'b1;
    bit_q = 1'b1;
    sclk = 1'b1;
    repeat (4) @(negedge clk);
    bit_q = 1'b0;
    repeat (4) @(negedge clk);
    for (int n = 0; n < 36; n++) begin
      sclk = 1'b0;
      repeat (2) @(negedge clk);
      bit_q = (n % 9 == 8) ? 1'b1 : b[31 - n + n / 9];
      repeat (2) @(negedge clk);
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      if (n % 9 == 8 && sdio_line === 1'b0)
        acks++;
    end
    sclk = 1'b0;
    bit_q = 1'b0;
    repeat (4) @(negedge clk);
    sclk = 1'b1;
    repeat (4) @(negedge clk);
    bit_q = 1'b1;
    repeat (4) @(negedge clk);
    drv = 1'b0;
    sclk = 1'b0;
  endtask
endmodule

// file: clock_buffer_control_pins_tb.sv
// self-checking bench for the clock buffer control pins
`timescale 1ns/100ps
module clock_buffer_control_pins_tb;
  logic             clk = 1'b0, rst_n = 1'b0, rpin_n = 1'b1, sync_n = 1'b1;
  logic             in_sel = 1'b1, three_wire = 1'b0;
  logic [1:0]       sel = 2'h0;
  logic [3:0]       rc = 4'h0, clk_out;
  logic [2:0]       strap [6] = '{3'h7, 3'h0, 3'h0, 3'h0, 3'h3, 3'h6};
  logic [1:0]       std [4];
  clkbuf_pkg::src_t src;
  logic             pd, ref_diff, sdio_out, sdio_oe_n, sdo_out, sdo_oe_n;
  logic             cs_n, sclk, sdio_line;
  logic [15:0]      q;
  int               n_errors = 0, samples_checked = 0, cycles = 0;
  always #12.5 clk = ~clk;
  always @(negedge clk) rc <= rc + 4'h1;
  clock_buffer_control_pins uut (
    .CLK(clk), .RST_N(rst_n), .CE(1'b1), .RESET_PIN_N(rpin_n),
    .SYNC_PIN_N(sync_n), .IN_SEL(in_sel), .PROGRAM_SOURCE_SELECT_CODE(sel),
    .THREE_WIRE(three_wire), .CS_N(cs_n), .SCLK(sclk), .SDIO_IN(sdio_line),
    .SDIO_OUT(sdio_out), .SDIO_OE_N(sdio_oe_n), .SDO_OUT(sdo_out),
    .SDO_OE_N(sdo_oe_n), .REF_P(rc[1]), .REF_N(~rc[1]),
    .STRAP_DIVIDER_OUT_0(strap[0]), .STRAP_DIVIDER_OUT_1(strap[1]),
    .STRAP_DIVIDER_OUT_2(strap[2]), .STRAP_DIVIDER_OUT_3(strap[3]),
    .STRAP_LEVEL_GROUP_A(strap[4]), .STRAP_LEVEL_GROUP_B(strap[5]),
    .CLOCK_OUTPUT_0(clk_out[0]), .CLOCK_OUTPUT_1(clk_out[1]),
    .CLOCK_OUTPUT_2(clk_out[2]), .CLOCK_OUTPUT_3(clk_out[3]),
    .OUT_STD_0(std[0]), .OUT_STD_1(std[1]), .OUT_STD_2(std[2]),
    .OUT_STD_3(std[3]), .PROG_SOURCE(src), .POWER_DOWN(pd),
    .REF_DIFF_MODE(ref_diff));
  serial_host host (.clk(clk), .i2c_mode(sel == 2'h1),
    .three_wire(three_wire), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .sdo_out(sdo_out), .cs_n(cs_n), .sclk(sclk), .sdio_line(sdio_line));
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_errors++;
      $display("wrong value at %0t: got %h, want %h", $time, seen, want);
    end
  endtask
  task automatic summarize;
    if (n_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic settle;
    repeat (8) @(negedge clk);
  endtask
  task automatic spi(input logic [23:0] f, input logic cs_on);
    host.spi_frame(f, cs_on, q);
    settle();
    check({sdo_oe_n, sdio_oe_n}, 2'h3);
  endtask
  task automatic pin_reset;
    rpin_n = 1'b0;
    settle();
    check(pd, 1'b1);
    check(clk_out, 4'h0);
    rpin_n = 1'b1;
    settle();
    check(pd, 1'b0);
  endtask
  // rising-edge to rising-edge distance of one output, in clock cycles
  task automatic period(input int k, input int want);
    logic prev;
    int n, first, p;
    first = -1;
    p = 0;
    prev = clk_out[k];
    for (n = 0; n < 9000 && p == 0; n++) begin
      @(negedge clk);
      if (!prev && clk_out[k] && first >= 0)
        p = n - first;
      if (!prev && clk_out[k])
        first = n;
      prev = clk_out[k];
    end
    check(p, want);
  endtask
  task automatic t_defaults;
    check(src, clkbuf_pkg::SRC_SPI);
    check(std[0], clkbuf_pkg::STD_DEFAULT);
    check(ref_diff, 1'b1);
    in_sel = 1'b0;
    settle();
    check(ref_diff, 1'b0);
    in_sel = 1'b1;
  endtask
  task automatic t_spi;
    spi({1'b0, 7'h04, 16'h0002}, 1'b0);
    check(std[0], clkbuf_pkg::STD_DEFAULT);
    spi({1'b0, 7'h04, 16'h0002}, 1'b1);
    check({std[1], std[0]}, {2{clkbuf_pkg::STD_CMOS}});
    spi({1'b1, 7'h04, 16'h0000}, 1'b1);
    check(q, 16'h0002);
    three_wire = 1'b1;
    spi({1'b1, 7'h04, 16'h0000}, 1'b1);
    check(q, 16'h0002);
    three_wire = 1'b0;
  endtask
  task automatic t_i2c;
    int acks;
    sel = clkbuf_pkg::SEL_I2C;
    settle();
    check(src, clkbuf_pkg::SRC_I2C);
    host.i2c_write({8'h60, 8'h05, 16'h0001}, acks);
    settle();
    check(acks, 4);
    check({std[3], std[2]}, {2{clkbuf_pkg::STD_HSTL}});
    sel = clkbuf_pkg::SEL_SPI;
    settle();
  endtask
  task automatic t_div;
    spi({1'b0, 7'h00, 16'h03ff}, 1'b1);
    spi({1'b0, 7'h01, 16'h0007}, 1'b1);
    period(0, 4096);
    period(1, 32);
  endtask
  task automatic t_sync;
    logic [3:0] prev, chg;
    sync_n = 1'b0;
    settle();
    check(clk_out, 4'h0);
    settle();
    check(clk_out, 4'h0);
    sync_n = 1'b1;
    prev = clk_out;
    repeat (4200) begin
      @(negedge clk);
      chg = clk_out ^ prev;
      if (chg[0])
        check(chg[1], 1'b1);
      if (chg[1])
        check(clk_out[2] & ~prev[2], 1'b1);
      prev = clk_out;
    end
  endtask
  task automatic t_pin;
    pin_reset();
    check(std[0], clkbuf_pkg::STD_DEFAULT);
    spi({1'b1, 7'h00, 16'h0000}, 1'b1);
    check(q, 16'h0000);
  endtask
  task automatic t_strap;
    sel = 2'h2;
    pin_reset();
    check(src, clkbuf_pkg::SRC_STRAP);
    check(std[0], clkbuf_pkg::STD_HSTL);
    check(std[3], clkbuf_pkg::STD_CMOS);
    period(0, 64);
    strap[4] = 3'h0;
    settle();
    check(std[1], clkbuf_pkg::STD_HSTL);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    settle();
    t_defaults();
    t_spi();
    t_i2c();
    t_div();
    t_sync();
    t_pin();
    t_strap();
    summarize();
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      summarize();
    end
  end
endmodule
